// ### pkg/rtc_pkg.sv
/*
 * constants, field layouts and types of the calendar clock unit.
 * assumes a 200 MHz system clock and a 32-bit apb register bus.
 */
package rtc_pkg;
   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_NS = 5;
   localparam int TICK_NS = 3906250;
   localparam int SW_NS = 10000000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int SW_CYC = SW_NS / CLK_NS;
   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_TIME = 8'h04;
   localparam logic [7:0] OFF_DATE = 8'h08;
   localparam logic [7:0] OFF_ALRM = 8'h0c;
   localparam logic [7:0] OFF_FLAG = 8'h10;
   localparam logic [7:0] OFF_IEN = 8'h14;
   localparam logic [7:0] OFF_SW = 8'h18;
   localparam logic [7:0] OFF_TRIM = 8'h1c;
   // ****************************************************************
   // bit positions
   // ****************************************************************
   localparam int B_RUN = 0;
   localparam int B_HOLD = 1;
   localparam int B_ADJ = 2;
   localparam int B_H24 = 3;
   localparam int B_BUSY = 4;
   localparam int B_TBUSY = 5;
   localparam int B_SWCLR = 0;
   localparam int B_SWGO = 1;
   localparam int F_ALM = 0;
   localparam int F_SEC = 1;
   localparam int F_SW1 = 2;
   localparam int F_TRM = 3;
   localparam int NFLAG = 4;
   // ****************************************************************
   // types and reset values
   // ****************************************************************
   typedef struct packed {
      logic [2:0] wday;
      logic [7:0] year;
      logic [4:0] mon;
      logic [5:0] day;
      logic ampm;
      logic [5:0] hour;
      logic [6:0] min;
      logic [6:0] sec;
   } cal_t;
   localparam cal_t CAL_RST = '{wday: 3'h0, year: 8'h00, mon: 5'h01,
      day: 6'h01, ampm: 1'b0, hour: 6'h12, min: 7'h00, sec: 7'h00};
   localparam logic [7:0] SUB_RST = 8'h00;
   localparam logic [22:0] ALM_RST = 23'h00_0000;
endpackage

// ### rtl/rtc_calendar_stopwatch.sv
/*
 * bcd calendar clock with hold, adjust, trim, alarm and stopwatch.
 * assumes an apb master on the same clock and synchronous inputs.
 */
`timescale 1ns/10ps
module rtc_calendar_stopwatch
   import rtc_pkg::*;
#(
   parameter int TICK_CYC_P = TICK_CYC,
   parameter int SW_CYC_P = SW_CYC
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic osc_enable_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic irq_o,
   output logic one_second_o
);
   if (TICK_CYC_P < 2 || SW_CYC_P < 2) begin : g_bad
      $error("prescaler counts must be at least 2");
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [8:0] step_f(input logic [7:0] v,
      input logic [7:0] lo, input logic [7:0] hi, input logic inc);
      logic bad;
      logic [7:0] n;
      bad = (v > hi) || (v < lo) || (v[3:0] > 4'h9);
      n = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
      if (bad)
         step_f = {1'b0, lo};
      else if (!inc)
         step_f = {1'b0, v};
      else if (v == hi)
         step_f = {1'b1, lo};
      else
         step_f = {1'b0, n};
   endfunction

   function automatic logic leap(input logic [7:0] y);
      if (y == 8'h00)
         leap = 1'b0;
      else if (y[4])
         leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      else
         leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
   endfunction

   function automatic logic [7:0] dmax(input logic [4:0] m,
      input logic [7:0] y);
      unique case (m)
         5'h02: dmax = leap(y) ? 8'h29 : 8'h28;
         5'h04, 5'h06, 5'h09, 5'h11: dmax = 8'h30;
         default: dmax = 8'h31;
      endcase
   endfunction

   function automatic cal_t advance(input cal_t t, input logic h24);
      cal_t r;
      logic [8:0] s, m, h, d, mo, y, w;
      logic dinc, flip;
      s = step_f({1'b0, t.sec}, 8'h00, 8'h59, 1'b1);
      m = step_f({1'b0, t.min}, 8'h00, 8'h59, s[8]);
      if (h24)
         h = step_f({2'b00, t.hour}, 8'h00, 8'h23, m[8]);
      else
         h = step_f({2'b00, t.hour}, 8'h01, 8'h12, m[8]);
      flip = !h24 && m[8] && (t.hour == 6'h11);
      dinc = h24 ? h[8] : (flip && t.ampm);
      d = step_f({2'b00, t.day}, 8'h01, dmax(t.mon, t.year), dinc);
      mo = step_f({3'b000, t.mon}, 8'h01, 8'h12, d[8]);
      y = step_f(t.year, 8'h00, 8'h99, mo[8]);
      w = step_f({5'h00, t.wday}, 8'h00, 8'h06, dinc);
      r.sec = s[6:0];
      r.min = m[6:0];
      r.hour = h[5:0];
      r.ampm = t.ampm ^ flip;
      r.day = d[5:0];
      r.mon = mo[4:0];
      r.year = y[7:0];
      r.wday = w[2:0];
      advance = r;
   endfunction

   // ****************************************************************
   // bus decode
   // ****************************************************************
   logic wr, wr_ctrl, wr_trim, adj, tick, one_sec, do_step, sw1_set;
   assign wr = psel_i && penable_i && pwrite_i;
   assign wr_ctrl = wr && (paddr_i == OFF_CTRL);
   assign wr_trim = wr && (paddr_i == OFF_TRIM);
   assign adj = wr_ctrl && pwdata_i[B_ADJ];

   // ****************************************************************
   // timebase and calendar
   // ****************************************************************
   logic [31:0] pre_r, pre_nxt;
   logic [7:0] sub_r, sub_nxt;
   logic [6:0] trim_r, trim_nxt;
   logic [22:0] alm_r, alm_nxt;
   logic [NFLAG-1:0] flag_r, flag_nxt, en_r, en_nxt;
   cal_t cal_r, cal_nxt, upd;
   logic run_r, run_nxt, hold_r, hold_nxt, h24_r, h24_nxt;
   logic pend_r, pend_nxt, busy_r, busy_nxt, tbusy_r, tbusy_nxt;
   logic trm_set, alm_hit;

   assign tick = osc_enable_i && (pre_r == 32'(TICK_CYC_P - 1));
   assign one_sec = tick && (sub_r == 8'hff);
   assign do_step = run_r && !hold_r && !adj
      && (one_sec || pend_r);

   always_comb begin
      pre_nxt = pre_r;
      sub_nxt = sub_r;
      trim_nxt = trim_r;
      tbusy_nxt = tbusy_r;
      trm_set = 1'b0;
      if (tick)
         pre_nxt = 32'h0000_0000;
      else if (osc_enable_i)
         pre_nxt = pre_r + 32'h0000_0001;
      if (tick) begin
         sub_nxt = sub_r + 8'h01;
         if (sub_r == 8'h7e && tbusy_r) begin
            sub_nxt = 8'h7f + {trim_r[6], trim_r};
            tbusy_nxt = 1'b0;
            trm_set = 1'b1;
         end
      end
      if (wr_trim && !tbusy_r) begin
         trim_nxt = pwdata_i[6:0];
         tbusy_nxt = 1'b1;
      end
      run_nxt = run_r;
      hold_nxt = hold_r;
      h24_nxt = h24_r;
      if (wr_ctrl) begin
         run_nxt = pwdata_i[B_RUN];
         hold_nxt = pwdata_i[B_HOLD] && !tbusy_r;
         h24_nxt = pwdata_i[B_H24];
      end
      pend_nxt = pend_r;
      if (run_r && hold_r && one_sec)
         pend_nxt = 1'b1;
      else if (do_step)
         pend_nxt = 1'b0;
      upd = cal_r;
      if (cal_r.sec >= 7'h30) begin
         upd.sec = 7'h59;
         upd = advance(upd, h24_r);
      end else begin
         upd.sec = 7'h00;
      end
      if (!adj)
         upd = advance(cal_r, h24_r);
      cal_nxt = cal_r;
      if (adj || do_step)
         cal_nxt = upd;
      if (wr && paddr_i == OFF_TIME) begin
         cal_nxt.sec = pwdata_i[6:0];
         cal_nxt.min = pwdata_i[14:8];
         cal_nxt.hour = pwdata_i[21:16];
         cal_nxt.ampm = pwdata_i[22];
      end
      if (wr && paddr_i == OFF_DATE) begin
         cal_nxt.day = pwdata_i[5:0];
         cal_nxt.mon = pwdata_i[12:8];
         cal_nxt.year = pwdata_i[23:16];
         cal_nxt.wday = pwdata_i[26:24];
      end
      busy_nxt = busy_r;
      if (adj || do_step)
         busy_nxt = 1'b1;
      else if (tick)
         busy_nxt = 1'b0;
      alm_hit = (adj || do_step) && upd.sec == alm_r[6:0]
         && upd.min == alm_r[14:8] && upd.hour == alm_r[21:16]
         && (h24_r || upd.ampm == alm_r[22]);
      alm_nxt = alm_r;
      if (wr && paddr_i == OFF_ALRM)
         alm_nxt = pwdata_i[22:0];
      en_nxt = en_r;
      if (wr && paddr_i == OFF_IEN)
         en_nxt = pwdata_i[NFLAG-1:0];
      flag_nxt = flag_r;
      if (wr && paddr_i == OFF_FLAG)
         flag_nxt = flag_r & ~pwdata_i[NFLAG-1:0];
      flag_nxt[F_ALM] = flag_nxt[F_ALM] | alm_hit;
      flag_nxt[F_SEC] = flag_nxt[F_SEC] | do_step;
      flag_nxt[F_SW1] = flag_nxt[F_SW1] | sw1_set;
      flag_nxt[F_TRM] = flag_nxt[F_TRM] | trm_set;
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pre_r <= 32'h0000_0000;
         sub_r <= SUB_RST;
         trim_r <= 7'h00;
         tbusy_r <= 1'b0;
         run_r <= 1'b0;
         hold_r <= 1'b0;
         h24_r <= 1'b0;
         pend_r <= 1'b0;
         busy_r <= 1'b0;
         cal_r <= CAL_RST;
         alm_r <= ALM_RST;
         en_r <= '0;
         flag_r <= '0;
      end else begin
         pre_r <= pre_nxt;
         sub_r <= sub_nxt;
         trim_r <= trim_nxt;
         tbusy_r <= tbusy_nxt;
         run_r <= run_nxt;
         hold_r <= hold_nxt;
         h24_r <= h24_nxt;
         pend_r <= pend_nxt;
         busy_r <= busy_nxt;
         cal_r <= cal_nxt;
         alm_r <= alm_nxt;
         en_r <= en_nxt;
         flag_r <= flag_nxt;
      end
   end

   // ****************************************************************
   // stopwatch
   // ****************************************************************
   logic [31:0] swpre_r, swpre_nxt;
   logic [3:0] swh_r, swh_nxt, swt_r, swt_nxt;
   logic swgo_r, swgo_nxt, swtick;
   assign swtick = swgo_r && osc_enable_i
      && (swpre_r == 32'(SW_CYC_P - 1));

   always_comb begin
      swpre_nxt = swpre_r;
      swh_nxt = swh_r;
      swt_nxt = swt_r;
      swgo_nxt = swgo_r;
      sw1_set = 1'b0;
      if (swtick)
         swpre_nxt = 32'h0000_0000;
      else if (swgo_r && osc_enable_i)
         swpre_nxt = swpre_r + 32'h0000_0001;
      if (swtick) begin
         swh_nxt = (swh_r == 4'h9) ? 4'h0 : swh_r + 4'h1;
         if (swh_r == 4'h9) begin
            swt_nxt = (swt_r == 4'h9) ? 4'h0 : swt_r + 4'h1;
            sw1_set = (swt_r == 4'h9);
         end
      end
      if (wr && paddr_i == OFF_SW) begin
         swgo_nxt = pwdata_i[B_SWGO];
         if (pwdata_i[B_SWCLR]) begin
            swpre_nxt = 32'h0000_0000;
            swh_nxt = 4'h0;
            swt_nxt = 4'h0;
         end
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         swpre_r <= 32'h0000_0000;
         swh_r <= 4'h0;
         swt_r <= 4'h0;
         swgo_r <= 1'b0;
      end else begin
         swpre_r <= swpre_nxt;
         swh_r <= swh_nxt;
         swt_r <= swt_nxt;
         swgo_r <= swgo_nxt;
      end
   end

   // ****************************************************************
   // read back and outputs
   // ****************************************************************
   logic [31:0] prdata_r, prdata_nxt;
   logic hit;
   assign hit = (paddr_i[1:0] == 2'b00) && (paddr_i <= OFF_TRIM);

   always_comb begin
      prdata_nxt = prdata_r;
      if (psel_i && !penable_i) begin
         prdata_nxt = 32'h0000_0000;
         unique case (paddr_i)
            OFF_CTRL: begin
               prdata_nxt[B_RUN] = run_r;
               prdata_nxt[B_HOLD] = hold_r;
               prdata_nxt[B_H24] = h24_r;
               prdata_nxt[B_BUSY] = busy_r;
               prdata_nxt[B_TBUSY] = tbusy_r;
            end
            OFF_TIME: prdata_nxt = {9'h000, cal_r.ampm, cal_r.hour, 1'b0,
               cal_r.min, 1'b0, cal_r.sec};
            OFF_DATE: prdata_nxt = {5'h00, cal_r.wday, cal_r.year, 3'h0,
               cal_r.mon, 2'h0, cal_r.day};
            OFF_ALRM: prdata_nxt = {9'h000, alm_r};
            OFF_FLAG: prdata_nxt[NFLAG-1:0] = flag_r;
            OFF_IEN: prdata_nxt[NFLAG-1:0] = en_r;
            OFF_SW: prdata_nxt = {20'h0_0000, swt_r, swh_r,
               2'b00, swgo_r, 1'b0};
            OFF_TRIM: prdata_nxt[7] = tbusy_r;
            default: prdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         prdata_r <= 32'h0000_0000;
      else
         prdata_r <= prdata_nxt;
   end

   assign prdata_o = prdata_r;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !hit;
   assign irq_o = |(flag_r & en_r);
   assign one_second_o = sub_r[7];

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence s_release;
      run_r && !hold_r && pend_r && !adj;
   endsequence
   sequence s_trim_edge;
      tick && tbusy_r && sub_r == 8'h7e;
   endsequence

   property p_busy_on;
      do_step || adj |=> busy_r ##0 busy_r[*1] ##1 !tick || busy_r;
   endproperty
   a_busy_on: assert property (p_busy_on) else $error("busy not set");
   property p_busy_off;
      busy_r && tick && !do_step && !adj |=> !busy_r;
   endproperty
   a_busy_off: assert property (p_busy_off) else $error("busy stuck");
   property p_hold_pend;
      run_r && hold_r && one_sec |=> pend_r;
   endproperty
   a_hold_pend: assert property (p_hold_pend) else $error("tick lost");
   property p_plus_one;
      s_release |=> !pend_r && busy_r && flag_r[F_SEC];
   endproperty
   a_plus_one: assert property (p_plus_one) else $error("no +1 s");
   property p_adjust;
      adj |=> cal_r.sec == 7'h00 && busy_r;
   endproperty
   a_adjust: assert property (p_adjust) else $error("adjust failed");
   property p_trim_apply;
      s_trim_edge |=> sub_r == 8'h7f + {$past(trim_r[6]), $past(trim_r)}
         && !tbusy_r && flag_r[F_TRM];
   endproperty
   a_trim_apply: assert property (p_trim_apply) else $error("trim");
   property p_trim_block;
      tbusy_r && wr_trim |=> trim_r == $past(trim_r);
   endproperty
   a_trim_block: assert property (p_trim_block) else $error("trim wr");
   property p_hold_block;
      tbusy_r && wr_ctrl |=> !hold_r;
   endproperty
   a_hold_block: assert property (p_hold_block) else $error("hold");
   property p_set_wins;
      do_step && wr && paddr_i == OFF_FLAG |=> flag_r[F_SEC];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("flag lost");
   property p_hold_freeze;
      hold_r && !wr |=> cal_r == $past(cal_r);
   endproperty
   a_hold_freeze: assert property (p_hold_freeze) else $error("moved");
endmodule

// ### tb/rtc_irq_sink.sv
/*
 * interrupt controller stand-in: counts rises of the request.
 * assumes a level request on the unit's clock.
 */
`timescale 1ns/10ps
module rtc_irq_sink (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic irq_i,
   output logic [7:0] req_count_o
);
   logic irq_q_r;
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_q_r <= 1'b0;
         req_count_o <= 8'h00;
      end else begin
         irq_q_r <= irq_i;
         if (irq_i && !irq_q_r) begin
            req_count_o <= req_count_o + 8'h01;
         end
      end
   end
endmodule

// ### tb/rtc_calendar_stopwatch_tb_top.sv
/*
 * self-checking bench of the calendar clock unit.
 * assumes rtc_pkg and a shortened timebase.
 */
`timescale 1ns/10ps
module rtc_calendar_stopwatch_tb_top;
   import rtc_pkg::*;
   localparam int TK = 4;
   localparam logic [31:0] TM = 32'h007f_7f7f;
   localparam logic [31:0] DM = 32'h07ff_1f3f;
   typedef struct packed {
      logic [31:0] e;
      logic [31:0] m;
      logic err;
   } note_t;
   logic clock_i, sys_rst_i, osc_en, psel, penable, pwrite;
   logic [7:0] paddr, irq_cnt;
   logic [31:0] pwdata, prdata_o, rd, al;
   logic pready_o, pslverr_o, irq_o, one_second_o;
   int miscompares, tests_run, seed;
   time t0;
   note_t q[$];
   note_t n;
   logic [31:0] tab [7][5] = '{
      '{32'h8, 32'h0023_5959, 32'h0699_1231, 32'h0, 32'h0000_0101},
      '{32'h8, 32'h0023_5959, 32'h0104_0228, 32'h0, 32'h0204_0229},
      '{32'h8, 32'h0023_5959, 32'h0100_0228, 32'h0, 32'h0200_0301},
      '{32'h8, 32'h0025_1000, 32'h07a0_1332, 32'h1001, 32'h0000_0101},
      '{32'h0, 32'h0051_5959, 32'h0199_0131, 32'h0012_0000, 32'h0299_0201},
      '{32'h0, 32'h0011_5959, 32'h0199_0131, 32'h0052_0000, 32'h0199_0131},
      '{32'h0, 32'h0013_0000, 32'h0199_0131, 32'h0001_0001, 32'h0199_0131}};
   logic [31:0] adj [4][2] = '{'{32'h0010_0030, 32'h0010_0100},
      '{32'h0010_0529, 32'h0010_0500}, '{32'h0010_5930, 32'h0011_0000},
      '{32'h0010_0000, 32'h0010_0000}};
   logic [6:0] trm [3] = '{7'h05, 7'h40, 7'h3f};

   rtc_calendar_stopwatch #(.TICK_CYC_P(TK), .SW_CYC_P(4)) uut (
      .clock_i(clock_i), .sys_rst_i(sys_rst_i), .osc_enable_i(osc_en),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
      .one_second_o(one_second_o));
   rtc_irq_sink ic (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .irq_i(irq_o), .req_count_o(irq_cnt));

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic chk(input string w, input logic [31:0] e,
      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] e, input logic [31:0] m);
      q.push_back('{e: e, m: m, err: (a > 8'h1c) || (a[1:0] != 2'b00)});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      do @(posedge clock_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 32'h0, 32'h0);
   endtask
   task automatic rdx(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
      xfer(1'b0, a, 32'h0, e, m);
   endtask
   task automatic wait_os(input logic v);
      do @(posedge clock_i); while (one_second_o !== ~v);
      do @(posedge clock_i); while (one_second_o !== v);
   endtask
   task automatic wait_idle();
      do begin
         rdx(OFF_CTRL, 32'h0, 32'h20);
      end while (rd[B_BUSY] !== 1'b0);
   endtask
   function automatic logic [7:0] bcd(input int x);
      return {4'(x / 10), 4'(x % 10)};
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ****************************************************************
   // monitor, clock, watchdog
   // ****************************************************************
   always @(posedge clock_i) begin
      if (psel && penable && pready_o === 1'b1) begin
         n = q.pop_front();
         chk("pslverr", {31'h0, n.err}, {31'h0, pslverr_o});
         if (!pwrite) begin
            chk("prdata", n.e & n.m, prdata_o & n.m);
         end
      end
   end
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   initial begin
      repeat (60000) @(posedge clock_i);
      miscompares++;
      complete_run();
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      seed = 32'h7ddb;
      sys_rst_i = 1'b1;
      osc_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (10) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      @(posedge clock_i);
      rdx(OFF_CTRL, 32'h0, 32'h3f);
      rdx(OFF_TIME, 32'h0012_0000, TM);
      rdx(OFF_DATE, 32'h0000_0101, DM);
      rdx(8'h20, 32'h0, 32'hffff_ffff);
      wr(8'h22, 32'h1);
      rdx(OFF_CTRL, 32'h0, 32'h1);
      for (int i = 0; i < 3; i++) begin
         al = {8'h00, bcd(($random(seed) & 255) % 24),
            bcd(($random(seed) & 255) % 60), bcd(($random(seed) & 255) % 60)};
         wr(OFF_ALRM, al);
         rdx(OFF_ALRM, al, TM);
      end
      $display("test reset done");
      foreach (tab[i]) begin
         wr(OFF_CTRL, tab[i][0]);
         wait_os(1'b1);
         wait_idle();
         wr(OFF_TIME, tab[i][1]);
         wr(OFF_DATE, tab[i][2]);
         wr(OFF_CTRL, tab[i][0] | 32'h1);
         wait_os(1'b0);
         wr(OFF_CTRL, tab[i][0]);
         rdx(OFF_TIME, tab[i][3], TM);
         rdx(OFF_DATE, tab[i][4], DM);
      end
      $display("test calendar done");
      wr(OFF_CTRL, 32'h8);
      foreach (adj[i]) begin
         wr(OFF_TIME, adj[i][0]);
         wr(OFF_CTRL, 32'hc);
         rdx(OFF_TIME, adj[i][1], TM);
      end
      wr(OFF_TIME, 32'h0015_0000);
      wr(OFF_CTRL, 32'h0);
      rdx(OFF_TIME, 32'h0015_0000, TM);
      wr(OFF_CTRL, 32'h8);
      wait_idle();
      wr(OFF_TIME, 32'h0010_0000);
      wait_os(1'b1);
      wr(OFF_CTRL, 32'hb);
      repeat (512 * TK) @(posedge clock_i);
      rdx(OFF_TIME, 32'h0010_0000, TM);
      wr(OFF_CTRL, 32'h9);
      rdx(OFF_TIME, 32'h0010_0001, TM);
      osc_en <= 1'b0;
      repeat (512 * TK) @(posedge clock_i);
      rdx(OFF_TIME, 32'h0010_0001, TM);
      osc_en <= 1'b1;
      wr(OFF_CTRL, 32'h8);
      $display("test hold done");
      wr(OFF_TIME, 32'h0010_0000);
      wr(OFF_IEN, 32'h0);
      wr(OFF_ALRM, 32'h0010_0002);
      wr(OFF_FLAG, 32'hf);
      wait_os(1'b1);
      wr(OFF_CTRL, 32'h9);
      wait_os(1'b0);
      rdx(OFF_FLAG, 32'h0, 32'h1);
      wait_os(1'b0);
      rdx(OFF_FLAG, 32'h1, 32'h1);
      chk("irq_masked", 32'h0, {31'h0, irq_o});
      wr(OFF_IEN, 32'h1);
      chk("irq", 32'h1, {31'h0, irq_o});
      wr(OFF_FLAG, 32'h1);
      chk("irq_clr", 32'h0, {31'h0, irq_o});
      chk("irq_count", 32'h1, {24'h0, irq_cnt});
      rdx(OFF_FLAG, 32'h0, 32'h1);
      wait_os(1'b0);
      wr(OFF_FLAG, 32'h2);
      repeat (256 * TK - 6) @(posedge clock_i);
      wr(OFF_FLAG, 32'h2);
      rdx(OFF_FLAG, 32'h2, 32'h2);
      wr(OFF_CTRL, 32'h8);
      $display("test alarm done");
      wr(OFF_SW, 32'h1);
      rdx(OFF_SW, 32'h0, 32'hff2);
      wr(OFF_SW, 32'h2);
      repeat (100) @(posedge clock_i);
      rdx(OFF_SW, 32'h2, 32'h2);
      wr(OFF_SW, 32'h0);
      rdx(OFF_SW, 32'h0, 32'h3);
      chk("sw_moved", 32'h1, {31'h0, rd[11:4] != 8'h00});
      al = rd;
      rdx(OFF_SW, 32'h0, 32'h3);
      chk("sw_reread", al, rd);
      wr(OFF_SW, 32'h1);
      rdx(OFF_SW, 32'h0, 32'hff0);
      $display("test stopwatch done");
      foreach (trm[i]) begin
         wait_os(1'b0);
         t0 = $time;
         wr(OFF_TRIM, {25'h0, trm[i]});
         rdx(OFF_TRIM, 32'h80, 32'h80);
         wr(OFF_TRIM, 32'h0);
         wr(OFF_CTRL, 32'h2);
         rdx(OFF_CTRL, 32'h0, 32'h2);
         wait_os(1'b0);
         chk("period", 32'((256 - int'($signed(trm[i]))) * TK),
            32'(($time - t0) / 5));
         rdx(OFF_FLAG, 32'h8, 32'h8);
         wr(OFF_FLAG, 32'h8);
         rdx(OFF_TRIM, 32'h0, 32'h80);
      end
      $display("test trim done");
      complete_run();
   end
endmodule
